// >>> inc/emd_pkg.sv
/*
  shared constants and types of the enclosure message decoder:
  message header and LED message field positions, LED codes, buffer and slot sizes.
  assumes a 32-bit message buffer, header in word 0, message bytes from word 1 on.
*/
package emd_pkg;

  // message buffer geometry
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int BPTR_W = 10;
  localparam logic [MEM_AW-1:0] HDR_IDX = 8'h00;
  localparam logic [MEM_AW-1:0] BODY_IDX = 8'h01;
  localparam logic [BPTR_W-1:0] FIRST_BYTE = 10'h004;

  // header fields
  localparam int MESSAGE_TYPE_FIELD_LSB = 24;
  localparam int MESSAGE_TYPE_FIELD_W = 4;
  localparam int PAYLEN_LSB = 16;
  localparam int MSGLEN_LSB = 8;
  localparam int LEN_W = 8;

  // LED message body fields, word 1
  localparam int PORT_LSB = 0;
  localparam int PORT_W = 5;
  localparam int ENC_BIT = 5;
  localparam int PMP_LSB = 8;
  localparam int PMP_W = 4;
  localparam int VAL_LSB = 16;
  localparam int VAL_W = 16;
  localparam int LED_NUM = 3;
  localparam int LED_W = 3;

  // implemented slots
  localparam int NUM_PORTS = 4;
  localparam int PSEL_W = 2;
  localparam int NUM_SLOTS = 64;
  localparam int SLOT_W = 6;
  localparam logic [PORT_W-1:0] PORT_LIMIT = 5'h04;
  localparam logic [LED_NUM-1:0] LED_IMPL = 3'h7;

  // LED control codes
  localparam logic [LED_W-1:0] LED_OFF = 3'h0;
  localparam logic [LED_W-1:0] LED_ON = 3'h1;
  localparam logic [LED_W-1:0] LED_VS0 = 3'h4;
  localparam logic [LED_W-1:0] LED_VS1 = 3'h5;
  localparam logic [LED_W-1:0] LED_VS2 = 3'h7;

  typedef enum logic [MESSAGE_TYPE_FIELD_W-1:0] {
    MT_LED = 4'h0,
    MT_SCSI_A = 4'h1,
    MT_SCSI_B = 4'h2,
    MT_SGPIO = 4'h3
  } emdMsgType_t;

  // led order: activity bits 2:0, locate 5:3, fault 8:6
  typedef struct packed {
    logic [LED_W-1:0] flt;
    logic [LED_W-1:0] loc;
    logic [LED_W-1:0] act;
  } emdLedCtl_t;

  localparam emdLedCtl_t LED_RST = 9'h000;

  // byte towards the enclosure processor
  typedef struct packed {
    logic inCdb;
    logic last;
    logic [MESSAGE_TYPE_FIELD_W-1:0] message_type_field;
    logic [7:0] data;
  } emdEpByte_t;

endpackage : emd_pkg

// >>> core/emd_msg_buffer.sv
/*
  message buffer memory: one write port from software, one read port for the decoder.
  assumes one clock; read data appear from a register one cycle after rdEn.
*/
`timescale 1ns/1ns
module emd_msg_buffer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write side
  input wire logic wrEn,
  input wire logic [emd_pkg::MEM_AW-1:0] wrIdx,
  input wire logic [31:0] wrData,
  // read side
  input wire logic rdEn,
  input wire logic [emd_pkg::MEM_AW-1:0] rdIdx,
  output logic [31:0] rdData_r
);

  logic [31:0] mem [emd_pkg::MEM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 32'h0000_0000;
    end else if (rdEn) begin
      rdData_r <= mem[rdIdx];
    end
  end

endmodule : emd_msg_buffer

// >>> core/emd_led_table.sv
/*
  per-slot LED state store, one entry per host port and port multiplier port.
  assumes the decoder gives one update pulse with a slot index and three codes.
*/
`timescale 1ns/1ns
module emd_led_table (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // update
  input wire logic updEn,
  input wire logic [emd_pkg::SLOT_W-1:0] updSlot,
  input wire emd_pkg::emdLedCtl_t updVal,
  // state
  output wire emd_pkg::emdLedCtl_t [emd_pkg::NUM_SLOTS-1:0] slotLeds
);

  logic [emd_pkg::LED_NUM-1:0] ledTake;

  // per led acceptance: implemented and code not reserved
  genvar l;
  generate
    for (l = 0; l < emd_pkg::LED_NUM; l++) begin : gLed
      wire logic [emd_pkg::LED_W-1:0] code = updVal[l*emd_pkg::LED_W +: emd_pkg::LED_W];
      wire logic codeOk = (code == emd_pkg::LED_OFF) || (code == emd_pkg::LED_ON)
        || (code == emd_pkg::LED_VS0) || (code == emd_pkg::LED_VS1) || (code == emd_pkg::LED_VS2);
      assign ledTake[l] = emd_pkg::LED_IMPL[l] && codeOk;
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < emd_pkg::NUM_SLOTS; s++) begin : gSlot
      wire logic hit = updEn && (updSlot == emd_pkg::SLOT_W'(s));
      emd_pkg::emdLedCtl_t st_r;
      emd_pkg::emdLedCtl_t st_nxt;
      always_comb begin
        st_nxt = st_r;
        for (int k = 0; k < emd_pkg::LED_NUM; k++) begin
          if (hit && ledTake[k]) begin
            st_nxt[k*emd_pkg::LED_W +: emd_pkg::LED_W] = updVal[k*emd_pkg::LED_W +: emd_pkg::LED_W];
          end
        end
      end
      // state held until this slot is addressed again
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= emd_pkg::LED_RST;
        end else begin
          st_r <= st_nxt;
        end
      end
      assign slotLeds[s] = st_r;
    end
  endgenerate

endmodule : emd_led_table

// >>> core/emd_message_decoder.sv
/*
  enclosure message decoder top: reads a message from the buffer on request,
  applies LED messages to the slot table and streams SCSI enclosure service
  messages (command block, then data) to the enclosure processor.
  assumes software leaves the buffer alone between xmitReq and xmitDone.
*/
`timescale 1ns/1ns

// Operation
// - an LED message controls up to three LEDs of one slot, three bits each.
// - code 000b off, 001b solid on; 010b, 011b reserved; 100b, 101b, 111b vendor.
// - value bits 2:0 activity, 5:3 locate, 8:6 fault, 15:9 ignored.
// - LED value sits in message bytes two and three after the header word.
// - byte one bits 3:0 give the port multiplier port, zero without one.
// - byte zero bits 4:0 give the host controller port of the slot.
// - byte zero bit 5 set makes value enclosure-wide and port bits ignored.
// - slot LED state holds until a later message addresses the same slot.
// - command block length in bytes comes from the message length field.
// - trailing data length in bytes comes from the payload length field.
// - header bits 27:24 give message type: LED, two SCSI kinds, serial GPIO; the code flags serial GPIO as bad.
// - header bits 15:8 give message length without header; zero is invalid.
// - header bits 23:16 give data buffer length, zero when none.
module emd_message_decoder (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // message buffer write
  input wire logic bufWe,
  input wire logic [emd_pkg::MEM_AW-1:0] bufWrIdx,
  input wire logic [31:0] bufWrData,
  // control and status
  input wire logic xmitReq,
  output logic busy,
  output logic xmitDone,
  output logic msgBad,
  // LED state
  output emd_pkg::emdLedCtl_t [emd_pkg::NUM_SLOTS-1:0] slotLeds,
  output logic [emd_pkg::VAL_W-1:0] encWideValue,
  output logic encWideStb,
  // enclosure processor byte stream
  output logic epValid,
  output emd_pkg::emdEpByte_t epOut,
  input wire logic epReady
);

  typedef enum logic [2:0] {
    IDLE = 3'h0,
    HREQ = 3'h1,
    HCHK = 3'h3,
    SREQ = 3'h2,
    SOUT = 3'h6,
    DONE = 3'h4,
    LAPP = 3'h7
  } emdState_t;

  emdState_t state_r;
  emdState_t state_nxt;

  // state decode
  wire logic stIdle = (state_r == IDLE);
  wire logic stHdrReq = (state_r == HREQ);
  wire logic stHdrChk = (state_r == HCHK);
  wire logic stStrReq = (state_r == SREQ);
  wire logic stStrOut = (state_r == SOUT);
  wire logic stLedApp = (state_r == LAPP);

  // buffer read
  logic rdEn;
  logic [emd_pkg::MEM_AW-1:0] rdIdx;
  logic [31:0] rdData;

  // stream pointers in bytes from buffer start
  logic [emd_pkg::BPTR_W-1:0] bytePtr_r;
  logic [emd_pkg::BPTR_W-1:0] bytePtr_nxt;
  logic [emd_pkg::BPTR_W-1:0] endPtr_r;
  logic [emd_pkg::BPTR_W-1:0] endPtr_nxt;
  logic [emd_pkg::BPTR_W-1:0] cdbEnd_r;
  logic [emd_pkg::BPTR_W-1:0] cdbEnd_nxt;
  logic [emd_pkg::MESSAGE_TYPE_FIELD_W-1:0] message_type_field_r;
  logic [emd_pkg::MESSAGE_TYPE_FIELD_W-1:0] message_type_field_nxt;

  // outcome flags
  logic done_r;
  logic done_nxt;
  logic bad_r;
  logic bad_nxt;
  logic [emd_pkg::VAL_W-1:0] encVal_r;
  logic [emd_pkg::VAL_W-1:0] encVal_nxt;
  logic encStb_r;
  logic encStb_nxt;

  // header decode
  wire logic [emd_pkg::MESSAGE_TYPE_FIELD_W-1:0] hdrType = rdData[emd_pkg::MESSAGE_TYPE_FIELD_LSB +: emd_pkg::MESSAGE_TYPE_FIELD_W];
  wire logic [emd_pkg::LEN_W-1:0] hdrMsgLen = rdData[emd_pkg::MSGLEN_LSB +: emd_pkg::LEN_W];
  wire logic [emd_pkg::LEN_W-1:0] hdrPayLen = rdData[emd_pkg::PAYLEN_LSB +: emd_pkg::LEN_W];
  wire logic typeLed = (hdrType == emd_pkg::MT_LED);
  wire logic typeScsi = (hdrType == emd_pkg::MT_SCSI_A) || (hdrType == emd_pkg::MT_SCSI_B);
  wire logic lenZero = (hdrMsgLen == 8'h00);
  wire logic msgOk = !lenZero && (typeLed || typeScsi);
  wire logic [emd_pkg::BPTR_W-1:0] hdrCdbEnd = emd_pkg::FIRST_BYTE
    + {{(emd_pkg::BPTR_W-emd_pkg::LEN_W){1'b0}}, hdrMsgLen};
  wire logic [emd_pkg::BPTR_W-1:0] hdrEnd = hdrCdbEnd
    + {{(emd_pkg::BPTR_W-emd_pkg::LEN_W){1'b0}}, hdrPayLen};

  // LED message body decode, word 1
  wire logic [emd_pkg::PORT_W-1:0] ledPort = rdData[emd_pkg::PORT_LSB +: emd_pkg::PORT_W];
  wire logic ledEnc = rdData[emd_pkg::ENC_BIT];
  wire logic [emd_pkg::PMP_W-1:0] ledPmp = rdData[emd_pkg::PMP_LSB +: emd_pkg::PMP_W];
  wire logic [emd_pkg::VAL_W-1:0] ledValue = rdData[emd_pkg::VAL_LSB +: emd_pkg::VAL_W];
  wire emd_pkg::emdLedCtl_t ledCodes = ledValue[emd_pkg::LED_NUM*emd_pkg::LED_W-1:0];
  wire logic portOk = (ledPort < emd_pkg::PORT_LIMIT);
  wire logic [emd_pkg::SLOT_W-1:0] ledSlot = {ledPort[emd_pkg::PSEL_W-1:0], ledPmp};
  wire logic ledUpd = stLedApp && !ledEnc && portOk;

  // stream byte selection
  wire logic [1:0] byteLane = bytePtr_r[1:0];
  wire logic [emd_pkg::BPTR_W-1:0] bytePtrInc = bytePtr_r + 10'h001;
  wire logic lastByte = (bytePtrInc == endPtr_r);
  wire logic [7:0] laneByte = rdData[{byteLane, 3'h0} +: 8];
  wire logic streamTake = stStrOut && epReady;
  wire logic laneWrap = (byteLane == 2'h3);

  emd_msg_buffer uBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wrEn(bufWe),
    .wrIdx(bufWrIdx),
    .wrData(bufWrData),
    .rdEn(rdEn),
    .rdIdx(rdIdx),
    .rdData_r(rdData)
  );

  emd_led_table uLeds (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .updEn(ledUpd),
    .updSlot(ledSlot),
    .updVal(ledCodes),
    .slotLeds(slotLeds)
  );

  // buffer read address per state
  assign rdEn = stHdrReq || stHdrChk || stStrReq;
  assign rdIdx = stHdrReq ? emd_pkg::HDR_IDX
    : stHdrChk ? emd_pkg::BODY_IDX
    : bytePtr_r[emd_pkg::BPTR_W-1:2];

  // sequencer
  always_comb begin
    state_nxt = state_r;
    bytePtr_nxt = bytePtr_r;
    endPtr_nxt = endPtr_r;
    cdbEnd_nxt = cdbEnd_r;
    message_type_field_nxt = message_type_field_r;
    done_nxt = 1'b0;
    bad_nxt = 1'b0;
    encVal_nxt = encVal_r;
    encStb_nxt = 1'b0;
    unique case (state_r)
      IDLE: begin
        if (xmitReq) begin
          state_nxt = HREQ;
        end
      end
      HREQ: begin
        state_nxt = HCHK;
      end
      HCHK: begin
        message_type_field_nxt = hdrType;
        bytePtr_nxt = emd_pkg::FIRST_BYTE;
        cdbEnd_nxt = hdrCdbEnd;
        endPtr_nxt = hdrEnd;
        if (!msgOk) begin
          bad_nxt = 1'b1;
          state_nxt = DONE;
        end else if (typeLed) begin
          state_nxt = LAPP;
        end else begin
          state_nxt = SREQ;
        end
      end
      LAPP: begin
        if (ledEnc) begin
          encVal_nxt = ledValue;
          encStb_nxt = 1'b1;
        end
        state_nxt = DONE;
      end
      SREQ: begin
        state_nxt = SOUT;
      end
      SOUT: begin
        if (streamTake) begin
          bytePtr_nxt = bytePtrInc;
          if (lastByte) begin
            state_nxt = DONE;
          end else if (laneWrap) begin
            state_nxt = SREQ;
          end
        end
      end
      DONE: begin
        done_nxt = 1'b1;
        bad_nxt = bad_r;
        state_nxt = IDLE;
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bytePtr_r <= emd_pkg::FIRST_BYTE;
    end else begin
      bytePtr_r <= bytePtr_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      endPtr_r <= emd_pkg::FIRST_BYTE;
    end else begin
      endPtr_r <= endPtr_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cdbEnd_r <= emd_pkg::FIRST_BYTE;
    end else begin
      cdbEnd_r <= cdbEnd_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      message_type_field_r <= emd_pkg::MT_LED;
    end else begin
      message_type_field_r <= message_type_field_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_r <= 1'b0;
    end else begin
      bad_r <= bad_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      encVal_r <= 16'h0000;
    end else begin
      encVal_r <= encVal_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      encStb_r <= 1'b0;
    end else begin
      encStb_r <= encStb_nxt;
    end
  end

  // status outputs
  assign busy = !stIdle;
  assign xmitDone = done_r;
  assign msgBad = done_r && bad_r;
  assign encWideValue = encVal_r;
  assign encWideStb = encStb_r;

  // stream outputs, command block bytes first, then data bytes
  assign epValid = stStrOut;
  assign epOut = '{
    inCdb: (bytePtr_r < cdbEnd_r),
    last: lastByte,
    message_type_field: message_type_field_r,
    data: laneByte
  };

endmodule : emd_message_decoder

// >>> verif/emd_decoder_properties.sv
/*
  checker for the enclosure message decoder top ports.
  assumes one clock, async active-low reset, bound to every decoder instance.
*/
`timescale 1ns/1ns
module emd_decoder_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control and status
  input wire logic xmitReq,
  input wire logic busy,
  input wire logic xmitDone,
  input wire logic msgBad,
  input wire logic encWideStb,
  input wire emd_pkg::emdLedCtl_t [emd_pkg::NUM_SLOTS-1:0] slotLeds,
  // stream
  input wire logic epValid,
  input wire emd_pkg::emdEpByte_t epOut,
  input wire logic epReady
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_req_busy: assert property (xmitReq && !busy |=> busy)
    else $error("busy not raised after request");
  a_req_done: assert property (xmitReq && !busy |-> ##[4:1000] xmitDone)
    else $error("request never completed");
  a_bad_done: assert property (msgBad |-> xmitDone && $past(xmitReq, 4) && !$past(busy, 4))
    else $error("bad flag without done");
  a_wide_done: assert property (encWideStb |=> xmitDone && !busy)
    else $error("done not after enclosure-wide update");
  a_ep_hold: assert property (epValid && !epReady |=> epValid && $stable(epOut))
    else $error("stream byte dropped or changed");
  a_ep_type: assert property (epValid |-> epOut.message_type_field inside {4'h1, 4'h2})
    else $error("stream byte of wrong type");
  a_cdb_order: assert property (epValid && !epOut.inCdb |=> !(epValid && epOut.inCdb))
    else $error("command byte after data byte");
  a_last_done: assert property (epValid && epReady && epOut.last |-> ##2 xmitDone)
    else $error("done not two cycles after last byte");
  a_ep_idle: assert property (xmitDone |-> !busy && !epValid)
    else $error("stream or busy active at completion");
  a_leds_hold: assert property (!busy |=> $stable(slotLeds))
    else $error("slot LED state changed while idle");

  c_bad: cover property (msgBad);
  c_wide: cover property (encWideStb);
  c_last: cover property (epValid && epReady && epOut.last);
endmodule : emd_decoder_properties

bind emd_message_decoder emd_decoder_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .xmitReq(xmitReq), .busy(busy), .xmitDone(xmitDone),
  .msgBad(msgBad), .encWideStb(encWideStb), .slotLeds(slotLeds), .epValid(epValid), .epOut(epOut),
  .epReady(epReady));

// >>> verif/emd_ep_sink.sv
/*
  enclosure processor model: takes stream bytes and keeps them in order.
  assumes the bench selects prompt or slow acceptance through slow.
*/
`timescale 1ns/1ns
module emd_ep_sink (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // stream
  input wire logic epValid,
  input wire emd_pkg::emdEpByte_t epOut,
  input wire logic slow,
  output logic epReady
);
  logic [13:0] got[$];

  // slow mode accepts every other cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      epReady <= 1'b0;
    end else begin
      epReady <= slow ? !epReady : 1'b1;
      if (epValid && epReady) begin
        got.push_back(epOut);
      end
    end
  end
endmodule : emd_ep_sink

// >>> verif/emd_message_decoder_test.sv
/*
  bench for the enclosure message decoder: LED, bad and enclosure service messages.
  assumes a 25 MHz clock and the enclosure processor model on the stream side.
*/
`timescale 1ns/1ns
module emd_message_decoder_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bufWe = 1'b0;
  logic [7:0] bufWrIdx = 8'h00;
  logic [31:0] bufWrData = 32'h0;
  logic xmitReq = 1'b0;
  logic slow = 1'b0;
  logic busy, xmitDone, msgBad, encWideStb, epValid, epReady;
  emd_pkg::emdLedCtl_t [emd_pkg::NUM_SLOTS-1:0] leds;
  logic [15:0] wide;
  emd_pkg::emdEpByte_t epOut;
  int badCount = 0;
  int numChecks = 0;
  int wideCnt = 0;

  emd_message_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .bufWe(bufWe), .bufWrIdx(bufWrIdx),
    .bufWrData(bufWrData), .xmitReq(xmitReq), .busy(busy), .xmitDone(xmitDone), .msgBad(msgBad),
    .slotLeds(leds), .encWideValue(wide), .encWideStb(encWideStb), .epValid(epValid), .epOut(epOut),
    .epReady(epReady));
  emd_ep_sink sink (.core_clk(core_clk), .rst_n(rst_n), .epValid(epValid), .epOut(epOut), .slow(slow),
    .epReady(epReady));

  always #20 core_clk = ~core_clk;

  // enclosure-wide strobe pulses seen
  always @(negedge core_clk) begin
    if (encWideStb === 1'b1) begin
      wideCnt++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic endOfTest();
    if (badCount == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : endOfTest

  // write header and two body words, then request and wait for done
  task automatic run(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2, input logic bad);
    logic [31:0] w[3];
    int n;
    w = '{w0, w1, w2};
    n = 0;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #1;
      bufWe = 1'b1;
      bufWrIdx = 8'(i);
      bufWrData = w[i];
    end
    @(posedge core_clk);
    #1;
    bufWe = 1'b0;
    xmitReq = 1'b1;
    @(posedge core_clk);
    #1;
    xmitReq = 1'b0;
    chk("busy", {31'h0, busy}, 32'h1);
    while (xmitDone !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("done", {31'h0, xmitDone}, 32'h1);
    chk("msgBad", {31'h0, msgBad}, {31'h0, bad});
  endtask : run

  task automatic led(input logic [31:0] w1);
    run(32'h0000_0400, w1, 32'h0, 1'b0);
  endtask : led

  initial begin
    #(40 * 20000);
    badCount++;
    endOfTest();
  end

  initial begin
    logic [3:0] bt[3];
    int m;
    int p;
    bt = '{4'h3, 4'h5, 4'hF};
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk("slot35 reset", 32'(leds[35]), 32'h0);
    chk("wide reset", {16'h0, wide}, 32'h0);
    led(32'hFF61_0302);
    chk("slot35", 32'(leds[35]), 32'h161);
    chk("slot3", 32'(leds[3]), 32'h0);
    led(32'h019A_0302);
    chk("slot35 reserved", 32'(leds[35]), 32'h161);
    led(32'h00F8_0302);
    chk("slot35 mixed", 32'(leds[35]), 32'h178);
    led(32'h0001_0001);
    chk("slot16", 32'(leds[16]), 32'h001);
    chk("slot35 held", 32'(leds[35]), 32'h178);
    led(32'h0000_0005);
    chk("slot16 port5", 32'(leds[16]), 32'h001);
    led(32'hABCD_0322);
    chk("wide", {16'h0, wide}, 32'hABCD);
    chk("wide strobe", 32'(wideCnt), 32'h1);
    chk("slot35 wide", 32'(leds[35]), 32'h178);
    run(32'h0000_0000, 32'h0000_0302, 32'h0, 1'b1);
    chk("slot35 zero len", 32'(leds[35]), 32'h178);
    for (int i = 0; i < 3; i++) begin
      run({4'h0, bt[i], 24'h00_0400}, 32'h0000_0302, 32'h0, 1'b1);
    end
    for (int t = 1; t < 3; t++) begin
      m = 2 + t;
      p = 3 - t;
      slow = (t == 2);
      sink.got.delete();
      run({4'h0, 4'(t), 8'(p), 8'(m), 8'h00}, 32'h1312_1110, 32'h0000_0014, 1'b0);
      chk("byte count", 32'(sink.got.size()), 32'(m + p));
      for (int k = 0; k < m + p; k++) begin
        chk("ep byte", 32'(sink.got[k]), {18'h0, k < m, k == m + p - 1, 4'(t), 8'(16 + k)});
      end
    end
    endOfTest();
  end
endmodule : emd_message_decoder_test
